// file: design/sdcl_divider.sv
// modulo counter advanced by a step strobe, with a wrap pulse and a half-period level
// assumes step_i comes from logic on clk_i
`default_nettype none

module sdcl_divider #(
   parameter int W = 9
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // control
   input wire logic step_i,
   input wire logic [W-1:0] modulus_i,
   // results
   output logic wrap_o,
   output logic level_o
);

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic [W:0] count_inc;
   logic at_end;
   logic [W-1:0] half;

   // a modulus of zero or one wraps every step instead of hanging
   assign count_inc = {1'b0, count} + {{W{1'b0}}, 1'b1};
   assign at_end = count_inc >= {1'b0, modulus_i};
   assign wrap_o = step_i & at_end;
   assign half = modulus_i >> 1;
   assign next_count = at_end ? '0 : count_inc[W-1:0];

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         count <= '0;
         level_o <= 1'b0;
      end else begin
         if (step_i) begin
            count <= next_count;
         end
         level_o <= count < half;
      end
   end

endmodule

`default_nettype wire

// file: design/sdcl_pkg.sv
// constants, field layouts and register map of the divider configuration logic
// assumes a single clock domain on clk_i; all pins are synchronised by the user of this package
`default_nettype none

package sdcl_pkg;

   // field widths
   localparam int M_W = 9;
   localparam int N_W = 2;
   localparam int T_W = 3;
   localparam int SR_W = 14;
   localparam int OUT_DIV_W = 5;
   localparam int REF_DIV_W = 5;
   localparam int Q_DIV_W = 3;

   // configuration word, laid out as the serial stream leaves it in the shift register
   typedef struct packed {
      logic [T_W-1:0] t;
      logic [N_W-1:0] n;
      logic [M_W-1:0] m;
   } sdcl_cfg_t;

   localparam sdcl_cfg_t CFG_RESET = '{t: 3'h0, n: 2'h0, m: 9'h000};
   localparam logic [T_W-1:0] TEST_FORCED = 3'h0;

   // fixed reference ratio and test output divider
   localparam logic [REF_DIV_W-1:0] REF_DIV = 5'h10;
   localparam logic [Q_DIV_W-1:0] FOUT_QUARTER_DIV = 3'h4;

   // output divider setting codes
   localparam logic [N_W-1:0] N_DIV1 = 2'h0;
   localparam logic [N_W-1:0] N_DIV2 = 2'h1;
   localparam logic [N_W-1:0] N_DIV4 = 2'h2;
   localparam logic [N_W-1:0] N_DIV8 = 2'h3;

   // output divider counts clk_i cycles; one output period is twice the ratio
   localparam logic [OUT_DIV_W-1:0] OUT_MOD1 = 5'h02;
   localparam logic [OUT_DIV_W-1:0] OUT_MOD2 = 5'h04;
   localparam logic [OUT_DIV_W-1:0] OUT_MOD4 = 5'h08;
   localparam logic [OUT_DIV_W-1:0] OUT_MOD8 = 5'h10;

   // test output source codes
   localparam logic [T_W-1:0] TEST_SHIFT_OUT = 3'h0;
   localparam logic [T_W-1:0] TEST_HIGH = 3'h1;
   localparam logic [T_W-1:0] TEST_FREF = 3'h2;
   localparam logic [T_W-1:0] TEST_MCOUNT = 3'h3;
   localparam logic [T_W-1:0] TEST_FOUT = 3'h4;
   localparam logic [T_W-1:0] TEST_LOW = 3'h5;
   localparam logic [T_W-1:0] TEST_BYPASS = 3'h6;
   localparam logic [T_W-1:0] TEST_FOUT_QUARTER = 3'h7;

   // register map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam int CTRL_SOFT_OE_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int STAT_CFG_LSB = 0;
   localparam int STAT_OE_BIT = 16;
   localparam int STAT_PAR_BIT = 17;
   localparam int STAT_BYPASS_BIT = 18;

   // bus codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   function automatic logic [OUT_DIV_W-1:0] out_modulus(input logic [N_W-1:0] n);
      logic [OUT_DIV_W-1:0] r;
      r = OUT_MOD1;
      if (n == N_DIV2) begin
         r = OUT_MOD2;
      end else if (n == N_DIV4) begin
         r = OUT_MOD4;
      end else if (n == N_DIV8) begin
         r = OUT_MOD8;
      end
      return r;
   endfunction

endpackage

`default_nettype wire

// file: design/sdcl_top.sv
// divider configuration logic of a crystal-referenced synthesizer, with AHB-Lite status port
// assumes pins arrive asynchronously; clk_i stands in for the oscillator that feeds the dividers
//
// Overview of operation
// R1 - crystal reference divided by sixteen before phase comparison
// R2 - loop divider modulus from serial or parallel path, fed back for comparison
// R3 - loop divider setting is nine bits, bit 8 most significant
// R4 - output divider ratios one, two, four, eight with fifty percent duty
// R5 - parallel divider inputs captured on rising edge of low-active load strobe
// R6 - parallel latches transparent while parallel load strobe is low
// R7 - controller holds parallel inputs stable around strobe rising edge
// R8 - parallel path wins over serial path
// R9 - controller holds parallel strobe low through reset, then releases it
// R10 - fourteen-bit shift register shifts on each serial clock rising edge
// R11 - serial contents latched on falling edge of serial load
// R12 - serial latches transparent while serial load is high
// R13 - controller keeps shifted data stable across serial load falling edge
// R14 - three serial-only test bits select the test output source
// R15 - output enable active high, applied synchronously, no runt pulses
// R16 - serial order: test bits, output divider bits, loop bits, msb first
// R17 - output divider code 01 divides by two
// R18 - test bits forced to zero while parallel strobe is low
// R19 - serial loading acts only while parallel strobe is high
// R20 - disabled output parks low, changes only at output period boundaries
`default_nettype none

module sdcl_top #(
   parameter int M_WIDTH = sdcl_pkg::M_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // crystal oscillator output
   input wire logic ref_osc_i,
   // parallel configuration pins
   input wire logic [M_WIDTH-1:0] par_m_i,
   input wire logic [sdcl_pkg::N_W-1:0] par_n_i,
   input wire logic par_load_n_i,
   // serial configuration port
   input wire logic ser_clock_i,
   input wire logic ser_data_i,
   input wire logic ser_load_i,
   // output enable pin
   input wire logic oe_i,
   // synthesizer outputs
   output logic fout_o,
   output logic fout_n_o,
   output logic test_o,
   output logic ref_div_o,
   output logic fb_div_o,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o
);

   localparam int SYNC_W = M_WIDTH + sdcl_pkg::N_W + 6;

   // two-stage synchroniser for every pin
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;

   assign pins_raw = {ref_osc_i, par_m_i, par_n_i, par_load_n_i,
                      ser_clock_i, ser_data_i, ser_load_i, oe_i};

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= pins_raw;
         sync_b <= sync_a;
      end
   end

   logic ref_s;
   logic [M_WIDTH-1:0] par_m_s;
   logic [sdcl_pkg::N_W-1:0] par_n_s;
   logic par_load_n_s;
   logic ser_clock_s;
   logic ser_data_s;
   logic ser_load_s;
   logic oe_s;

   assign {ref_s, par_m_s, par_n_s, par_load_n_s,
           ser_clock_s, ser_data_s, ser_load_s, oe_s} = sync_b;

   // edge detection on synchronised levels only
   logic ref_prev;
   logic ser_clock_prev;
   logic ref_rise;
   logic ser_clock_rise;

   assign ref_rise = ref_s & ~ref_prev;
   assign ser_clock_rise = ser_clock_s & ~ser_clock_prev;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ref_prev <= 1'b0;
         ser_clock_prev <= 1'b0;
      end else begin
         ref_prev <= ref_s;
         ser_clock_prev <= ser_clock_s;
      end
   end

   // serial shift register, first bit ends up at the top
   logic [sdcl_pkg::SR_W-1:0] shift_reg;
   logic [sdcl_pkg::SR_W-1:0] next_shift;
   sdcl_pkg::sdcl_cfg_t ser_word;

   assign next_shift = {shift_reg[sdcl_pkg::SR_W-2:0], ser_data_s}; // R10 R16
   assign ser_word = sdcl_pkg::sdcl_cfg_t'(shift_reg); // R16

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         shift_reg <= '0;
      end else if (ser_clock_rise) begin
         shift_reg <= next_shift; // R10
      end
   end

   // configuration latches: transparent phases modelled as follow-every-cycle
   sdcl_pkg::sdcl_cfg_t cfg;
   sdcl_pkg::sdcl_cfg_t par_word;
   sdcl_pkg::sdcl_cfg_t next_cfg;
   logic par_open;
   logic ser_open;

   assign par_word = '{t: sdcl_pkg::TEST_FORCED, n: par_n_s, m: par_m_s}; // R3 R18
   assign par_open = ~par_load_n_s; // R6
   assign ser_open = par_load_n_s & ser_load_s; // R12 R19
   // parallel first; holding on release gives the edge captures
   assign next_cfg = par_open ? par_word : (ser_open ? ser_word : cfg); // R5 R8 R11

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cfg <= sdcl_pkg::CFG_RESET;
      end else begin
         cfg <= next_cfg; // R5 R11
      end
   end

   // pll bypass: serial clock edges drive both dividers instead of the oscillator
   logic bypass;
   logic osc_step;

   assign bypass = cfg.t == sdcl_pkg::TEST_BYPASS;
   assign osc_step = bypass ? ser_clock_rise : 1'b1;

   // reference divider
   logic ref_level;

   sdcl_divider #(
      .W(sdcl_pkg::REF_DIV_W)
   ) u_ref_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .step_i(ref_rise),
      .modulus_i(sdcl_pkg::REF_DIV), // R1
      .wrap_o(),
      .level_o(ref_level)
   );

   // loop divider; its output is not 50% for odd moduli
   logic loop_level;

   sdcl_divider #(
      .W(M_WIDTH)
   ) u_loop_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .step_i(osc_step),
      .modulus_i(cfg.m), // R2 R3
      .wrap_o(),
      .level_o(loop_level)
   );

   // output divider
   logic [sdcl_pkg::OUT_DIV_W-1:0] out_mod;
   logic out_wrap;
   logic out_level;

   assign out_mod = sdcl_pkg::out_modulus(cfg.n); // R4 R17

   sdcl_divider #(
      .W(sdcl_pkg::OUT_DIV_W)
   ) u_out_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .step_i(osc_step),
      .modulus_i(out_mod), // R4
      .wrap_o(out_wrap),
      .level_o(out_level)
   );

   // software enable, anded with the pin
   logic [31:0] ctrl;
   logic oe_want;
   logic oe_active;
   logic fout;

   assign oe_want = oe_s & ctrl[sdcl_pkg::CTRL_SOFT_OE_BIT]; // R15

   // enable moves only at the wrap, while the output sits low, so no runts
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         oe_active <= 1'b0;
         fout <= 1'b0;
      end else begin
         if (out_wrap) begin
            oe_active <= oe_want; // R15 R20
         end
         fout <= out_level & oe_active; // R20
      end
   end

   assign fout_o = fout;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         fout_n_o <= 1'b1;
      end else begin
         fout_n_o <= ~(out_level & oe_active);
      end
   end

   // quarter-rate copy of the output for the test pin
   logic fout_prev;
   logic fout_rise;
   logic quarter_level;

   assign fout_rise = fout & ~fout_prev;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         fout_prev <= 1'b0;
      end else begin
         fout_prev <= fout;
      end
   end

   sdcl_divider #(
      .W(sdcl_pkg::Q_DIV_W)
   ) u_quarter_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .step_i(fout_rise),
      .modulus_i(sdcl_pkg::FOUT_QUARTER_DIV),
      .wrap_o(),
      .level_o(quarter_level)
   );

   // test output selection; any toggling here costs output jitter
   logic test_sel;

   assign test_sel =
      (cfg.t == sdcl_pkg::TEST_SHIFT_OUT) ? shift_reg[sdcl_pkg::SR_W-1] :
      (cfg.t == sdcl_pkg::TEST_HIGH) ? 1'b1 :
      (cfg.t == sdcl_pkg::TEST_FREF) ? ref_level :
      (cfg.t == sdcl_pkg::TEST_MCOUNT) ? loop_level :
      (cfg.t == sdcl_pkg::TEST_FOUT) ? fout :
      (cfg.t == sdcl_pkg::TEST_LOW) ? 1'b0 :
      (cfg.t == sdcl_pkg::TEST_BYPASS) ? loop_level :
      quarter_level; // R14

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         test_o <= 1'b0;
      end else begin
         test_o <= test_sel; // R14
      end
   end

   assign ref_div_o = ref_level; // R1
   assign fb_div_o = loop_level; // R2

   // AHB-Lite slave, zero wait states
   logic addr_take;
   logic dph_valid;
   logic dph_write;
   logic [sdcl_pkg::ADDR_W-1:0] dph_addr;
   logic [31:0] status;
   logic [31:0] rd_mux;

   assign addr_take = hsel_i & hready_i & (htrans_i == sdcl_pkg::HTRANS_NONSEQ);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         dph_valid <= 1'b0;
         dph_write <= 1'b0;
         dph_addr <= '0;
      end else begin
         dph_valid <= addr_take;
         if (addr_take) begin
            dph_write <= hwrite_i;
            dph_addr <= haddr_i[sdcl_pkg::ADDR_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl <= sdcl_pkg::CTRL_RESET;
      end else if (dph_valid & dph_write & (dph_addr == sdcl_pkg::ADDR_CTRL)) begin
         ctrl <= {31'h0000_0000, hwdata_i[sdcl_pkg::CTRL_SOFT_OE_BIT]};
      end
   end

   always_comb begin
      status = '0;
      status[sdcl_pkg::STAT_CFG_LSB +: sdcl_pkg::SR_W] = cfg;
      status[sdcl_pkg::STAT_OE_BIT] = oe_active;
      status[sdcl_pkg::STAT_PAR_BIT] = par_open;
      status[sdcl_pkg::STAT_BYPASS_BIT] = bypass;
   end

   assign rd_mux = (dph_addr == sdcl_pkg::ADDR_CTRL) ? ctrl :
                   (dph_addr == sdcl_pkg::ADDR_STATUS) ? status : 32'h0000_0000;

   always_comb begin
      hrdata_o = 32'h0000_0000;
      if (dph_valid & ~dph_write) begin
         hrdata_o = rd_mux;
      end
   end

   assign hreadyout_o = 1'b1;
   assign hresp_o = sdcl_pkg::HRESP_OKAY;

endmodule

`default_nettype wire

// file: verification/sdcl_ctrl_model.sv
// system controller model: parallel pins and serial port
// assumes clk_i is the block clock; every pin moves just after its rising edge
`default_nettype none
module sdcl_ctrl_model (
   // timing
   input wire logic clk_i,
   // parallel pins
   output logic [8:0] par_m_o,
   output logic [1:0] par_n_o,
   output logic par_load_n_o,
   // serial port
   output logic ser_clock_o,
   output logic ser_data_o,
   output logic ser_load_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      par_m_o = 9'h1FF;
      par_n_o = 2'h3;
      par_load_n_o = 1'b0;
      ser_clock_o = 1'b0;
      ser_data_o = 1'b0;
      ser_load_o = 1'b0;
   end
   task automatic par_set(input logic [8:0] m, input logic [1:0] n, input logic strobe_n);
      @(posedge clk_i);
      par_m_o <= m;
      par_n_o <= n;
      par_load_n_o <= strobe_n;
      repeat (8) @(posedge clk_i);
   endtask
   // serial clock stands still low outside frames
   // eight clocks a bit: 32 ns serial clock, data moves mid-way through the low phase
   task automatic ser_cfg(input logic [13:0] w);
      for (int i = 13; i >= 0; i--) begin
         @(posedge clk_i);
         ser_data_o <= w[i];
         repeat (2) @(posedge clk_i);
         ser_clock_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         ser_clock_o <= 1'b0;
         @(posedge clk_i);
      end
      @(posedge clk_i);
      ser_data_o <= 1'b0;
      ser_load_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      ser_load_o <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// file: verification/sdcl_properties.sv
// port checks of the divider configuration logic
// assumes pins reach sdcl_top raw; STATUS is read back over the bus
`default_nettype none
module sdcl_checker #(
   parameter int M_WIDTH = 9
) (
   // clock, reset, pins
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ref_osc_i,
   input wire logic [M_WIDTH-1:0] par_m_i,
   input wire logic [sdcl_pkg::N_W-1:0] par_n_i,
   input wire logic par_load_n_i,
   input wire logic ser_load_i,
   input wire logic oe_i,
   // outputs
   input wire logic fout_o,
   input wire logic fout_n_o,
   input wire logic ref_div_o,
   input wire logic fb_div_o,
   // bus
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd_stat, pok, fbseen, refseen;
   logic [9:0] pstab, fcnt;
   logic [5:0] oecnt, hcnt;
   logic [4:0] rcnt;
   logic [2:0] since;
   logic [10:0] pcap;
   wire logic [10:0] pins;
   wire logic [10:0] plim;
   wire logic take;
   assign pins = {par_n_i, par_m_i};
   // margin: a loop period of the new modulus must start after it settles
   assign plim = 11'({par_m_i, 1'b0}) + 11'h040;
   assign take = hsel_i & hready_i & (htrans_i == sdcl_pkg::HTRANS_NONSEQ);
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rd_stat <= 1'b0;
         pok <= 1'b0;
         fbseen <= 1'b0;
         refseen <= 1'b0;
         pstab <= 10'h000;
         fcnt <= 10'h000;
         oecnt <= 6'h00;
         hcnt <= 6'h00;
         rcnt <= 5'h00;
         since <= 3'h0;
         pcap <= 11'h000;
      end else begin
         rd_stat <= take & !hwrite_i & (haddr_i[7:0] == sdcl_pkg::ADDR_STATUS);
         pok <= $rose(par_load_n_i) | (pok & par_load_n_i & !ser_load_i);
         since <= pok ? since + 3'(since != 3'h7) : 3'h0;
         pcap <= $rose(par_load_n_i) ? pins : pcap;
         pstab <= ($stable(pins) && $stable(par_load_n_i)) ?
                  pstab + 10'(pstab != 10'h3FF) : 10'h000;
         oecnt <= oe_i ? 6'h00 : oecnt + 6'(oecnt != 6'h3F);
         hcnt <= fout_o ? hcnt + 6'h01 : 6'h00;
         fcnt <= $rose(fb_div_o) ? 10'h001 : fcnt + 10'(fcnt != 10'h3FF);
         fbseen <= fbseen | $rose(fb_div_o);
         rcnt <= ($changed(ref_div_o) ? 5'h00 : rcnt) + 5'($rose(ref_osc_i));
         refseen <= refseen | $changed(ref_div_o);
      end
   end
   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   chk_fout_pair: assert property (fout_n_o == !fout_o)
      else $error("fout pair not complementary");
   chk_fout_half: assert property ($fell(fout_o) && !par_load_n_i && pstab > 10'h040
      |-> hcnt == (6'h01 << par_n_i)) else $error("fout half period wrong");
   chk_fout_park: assert property (oecnt > 6'h28 |-> !fout_o)
      else $error("fout runs while disabled");
   chk_test_forced: assert property (rd_stat && hrdata_o[sdcl_pkg::STAT_PAR_BIT]
      |-> hrdata_o[13:11] == sdcl_pkg::TEST_FORCED) else $error("test bits not forced");
   chk_par_follow: assert property (rd_stat && !par_load_n_i && pstab > 10'h006
      |-> hrdata_o[10:0] == pins) else $error("config not following pins");
   chk_par_hold: assert property (rd_stat && pok && since == 3'h7
      |-> hrdata_o[10:0] == pcap) else $error("captured config lost");
   chk_ref_sixteen: assert property ($changed(ref_div_o) && refseen |-> rcnt == 5'h08)
      else $error("reference half period not eight edges");
   chk_loop_period: assert property ($rose(fb_div_o) && fbseen && !par_load_n_i
      && 11'(pstab) > plim |-> fcnt == 10'(par_m_i)) else $error("loop period wrong");
   cov_ser_load: cover property ($fell(ser_load_i));
   cov_loop: cover property ($rose(fb_div_o) && fbseen);
   cov_park: cover property (oecnt > 6'h28);
endmodule
bind sdcl_top sdcl_checker #(.M_WIDTH(M_WIDTH)) u_chk (
   .clk_i(clk_i), .reset_i(reset_i), .ref_osc_i(ref_osc_i), .par_m_i(par_m_i),
   .par_n_i(par_n_i), .par_load_n_i(par_load_n_i), .ser_load_i(ser_load_i), .oe_i(oe_i),
   .fout_o(fout_o), .fout_n_o(fout_n_o), .ref_div_o(ref_div_o), .fb_div_o(fb_div_o),
   .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hready_i(hready_i), .hrdata_o(hrdata_o));
`default_nettype wire

// file: verification/synth_divider_config_logic_bench.sv
// self-checking bench for the divider configuration logic
// assumes the controller model drives the configuration pins
`default_nettype none
module synth_divider_config_logic_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic ref_osc = 1'b0;
   logic oe = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, fout, test, fb, pl_n, sclk, sdat, sld;
   logic [8:0] pm;
   logic [1:0] pn;
   int mismatches = 0;
   int n_tests = 0;
   always #2 clk_i = ~clk_i;
   always begin
      repeat (5) @(posedge clk_i);
      ref_osc <= ~ref_osc;
   end
   sdcl_ctrl_model ctl (.clk_i(clk_i), .par_m_o(pm), .par_n_o(pn), .par_load_n_o(pl_n),
      .ser_clock_o(sclk), .ser_data_o(sdat), .ser_load_o(sld));
   sdcl_top dut (.clk_i(clk_i), .reset_i(reset_i), .ref_osc_i(ref_osc), .par_m_i(pm),
      .par_n_i(pn), .par_load_n_i(pl_n), .ser_clock_i(sclk), .ser_data_i(sdat),
      .ser_load_i(sld), .oe_i(oe), .fout_o(fout), .fout_n_o(), .test_o(test),
      .ref_div_o(), .fb_div_o(fb), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
      .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o());
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // each phase held until hready is seen at a rising edge; read data taken there
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk_i);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= sdcl_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk_i); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_i); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask
   // high time of fout or fb, after skipping whole periods
   task automatic len(input logic sel, input int skip, output int c);
      int k;
      c = 0;
      k = 0;
      @(negedge clk_i);
      repeat (skip + 1) begin
         while ((sel ? fb : fout) !== 1'b0 && k < 200) begin
            @(negedge clk_i);
            k++;
         end
         while ((sel ? fb : fout) !== 1'b1 && k < 200) begin
            @(negedge clk_i);
            k++;
         end
      end
      while ((sel ? fb : fout) === 1'b1 && k < 200) begin
         @(negedge clk_i);
         c++;
         k++;
      end
   endtask
   task automatic t_par();
      logic [31:0] d;
      int c;
      for (int n = 0; n < 4; n++) begin
         ctl.par_set(9'h00A, 2'(n), 1'b0);
         bus(1'b0, 32'(sdcl_pkg::ADDR_STATUS), 32'h0, d);
         chk(d[13:0], {3'h0, 2'(n), 9'h00A});
         len(1'b0, 1, c);
         chk(c, 32'h1 << n);
      end
      repeat (40) @(posedge clk_i);
      len(1'b1, 1, c);
      chk(c, 32'h5);
      ctl.par_set(9'h106, sdcl_pkg::N_DIV2, 1'b0);
      ctl.par_set(9'h106, sdcl_pkg::N_DIV2, 1'b1);
      ctl.par_set(9'h0F0, sdcl_pkg::N_DIV8, 1'b1);
      bus(1'b0, 32'(sdcl_pkg::ADDR_STATUS), 32'h0, d);
      chk(d[13:0], {3'h0, sdcl_pkg::N_DIV2, 9'h106});
      $display("t_par done");
   endtask
   task automatic t_ser();
      logic [31:0] d;
      logic [13:0] w;
      logic f;
      for (int i = 0; i < 3; i++) begin
         w = (i == 0) ? {sdcl_pkg::TEST_HIGH, sdcl_pkg::N_DIV4, 9'h0C3} :
             (i == 1) ? {sdcl_pkg::TEST_LOW, sdcl_pkg::N_DIV1, 9'h155} :
             {sdcl_pkg::TEST_BYPASS, sdcl_pkg::N_DIV2, 9'h004};
         ctl.ser_cfg(w);
         bus(1'b0, 32'(sdcl_pkg::ADDR_STATUS), 32'h0, d);
         chk(d[13:0], w);
         chk(d[sdcl_pkg::STAT_BYPASS_BIT], 1'(i == 2));
         @(negedge clk_i);
         f = fout;
         if (i < 2) begin
            chk(test, i ? 1'b0 : 1'b1);
         end else begin
            // bypass: dividers step on serial clock only, which now stands still
            repeat (40) @(negedge clk_i);
            chk(fout, f);
         end
      end
      $display("t_ser done");
   endtask
   task automatic t_prio();
      logic [31:0] d;
      ctl.par_set(9'h021, sdcl_pkg::N_DIV8, 1'b0);
      ctl.ser_cfg({sdcl_pkg::TEST_HIGH, sdcl_pkg::N_DIV2, 9'h1FF});
      bus(1'b0, 32'(sdcl_pkg::ADDR_STATUS), 32'h0, d);
      chk(d[13:0], {3'h0, sdcl_pkg::N_DIV8, 9'h021});
      ctl.par_set(9'h021, sdcl_pkg::N_DIV8, 1'b1);
      bus(1'b0, 32'(sdcl_pkg::ADDR_STATUS), 32'h0, d);
      chk(d[13:0], {3'h0, sdcl_pkg::N_DIV8, 9'h021});
      $display("t_prio done");
   endtask
   task automatic t_oe();
      logic [31:0] d;
      int c;
      oe <= 1'b0;
      repeat (48) @(posedge clk_i);
      c = 0;
      repeat (32) begin
         @(negedge clk_i);
         c += int'(fout !== 1'b0);
      end
      chk(c, 32'h0);
      @(posedge clk_i);
      oe <= 1'b1;
      len(1'b0, 0, c);
      chk(c, 32'h8);
      bus(1'b1, 32'h0000_0008, 32'h0, d);
      bus(1'b0, 32'(sdcl_pkg::ADDR_CTRL), 32'h0, d);
      chk(d, sdcl_pkg::CTRL_RESET);
      bus(1'b1, 32'(sdcl_pkg::ADDR_CTRL), 32'h0, d);
      // enable drops only at the next divider wrap
      repeat (20) @(posedge clk_i);
      bus(1'b0, 32'(sdcl_pkg::ADDR_STATUS), 32'h0, d);
      chk(d[sdcl_pkg::STAT_OE_BIT], 1'b0);
      $display("t_oe done");
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      t_par();
      t_ser();
      t_prio();
      t_oe();
      end_sim();
   end
   initial begin
      #40000;
      mismatches++;
      end_sim();
   end
endmodule
`default_nettype wire
